// [verilog/crtcp_host_port.sv]
// Summary of operation
// - Latch strobe fall captures request bit, select, index.
// - Selected when nibble equals 2, select low.
// - Unselected: pins float, registers unchanged.
// - Selected data phase accesses register while latched.
// - Register zero command/status; one-seven read/write.
// - Command byte: type nibble plus four parameters.
// - Direction one fills data registers.
// - Increment bit and pointer select bit.
// - Source field 01 primary-to-secondary, 10 reverse.
// - Stop field 01 buffer end, 10 never.
// - Status: busy, wrap, primary end, secondary end.
// - Start at transfer strobe end if requested.
// - Busy without request: only status reads.
// - Busy with request: command write aborts, restarts.
// - Pause during row edge scan lines.
// - Indirect moves byte with data register one.
// - Code widths 24, 16, 12, 8 bits.
// - Position 39 sets end flag, wraps row.
// - Byte access primary overflow increments row.
// - Eighty-column pairs packed in three buffers.
// - Long eighty write merges nibble by read-modify-write.
`timescale 1ns/1ps
`default_nettype none
module crtcp_host_port (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe_out,
  input  wire logic        latch_strobe_in,
  input  wire logic        transfer_strobe_n_in,
  input  wire logic        read_not_write_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        row_edge_in,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic      [15:0] mem_addr_out,
  output logic      [7:0]  mem_wdata_out,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        mem_ack_in,
  output logic             sync_mask_out
);
  typedef struct packed {
    logic                    as_s1, as_s2, as_d;
    logic                    ds_s1, ds_s2, ds_d;
    logic                    rw_s1, rw_s2, cs_s1, cs_s2;
    logic [7:0]              ad_s1, ad_s2;
    logic [2:0]              idx;
    logic                    execute_request_bit, sel;
    logic [7:0][7:0]         rf, indirect_transfer_cmd;
    logic                    busy, wrap, row_end_flag_primary, row_end_flag_secondary, smask;
    crtcp_pkg::crtcp_state_e state;
    logic [1:0]              step;
    logic [7:0]              hold, ad_out;
    logic                    ad_oe, mem_req, mem_we;
    logic [15:0]             mem_addr;
    logic [7:0]              mem_wdata;
  } crtcp_regs_s;

  crtcp_regs_s s_reg;
  crtcp_regs_s s_next;
  logic        as_fall, ds_rise, wr_hit, go;
  logic [7:0]  cmd, p_hi, p_lo, status, merged, rd_nib;
  logic [3:0]  typ;
  logic        dir, inc, is_move, is_mem, psec, use_sec, src_sec, susp;
  logic [2:0]  dst;
  logic [1:0]  last;
  logic [15:0] cur_addr, upd;
  logic        cur_we, at_end, end_hit;

  function automatic logic [1:0] step_last(logic [3:0] t, logic d);
    case (t)
      crtcp_pkg::TYP_L40P, crtcp_pkg::TYP_L40S: step_last = 2'h2;
      crtcp_pkg::TYP_S40P, crtcp_pkg::TYP_S40S: step_last = 2'h1;
      crtcp_pkg::TYP_L80: step_last = d ? 2'h1 : 2'h2;
      crtcp_pkg::TYP_S80, crtcp_pkg::TYP_BYTE: step_last = 2'h0;
      default: step_last = 2'h1;
    endcase
  endfunction

  function automatic logic [15:0] addr_of(logic [3:0] t, logic [1:0] k,
                                          logic [7:0] hi, logic [7:0] lo);
    case (t)
      crtcp_pkg::TYP_L40P, crtcp_pkg::TYP_L40S,
      crtcp_pkg::TYP_S40P, crtcp_pkg::TYP_S40S:
        addr_of = {hi, lo[7:6] + k, lo[5:0]};
      crtcp_pkg::TYP_L80:
        addr_of = {hi, (k == 2'h0) ? {1'b0, lo[0]} : crtcp_pkg::NIB_BUF, lo[6:1]};
      crtcp_pkg::TYP_S80:
        addr_of = {hi, 1'b0, lo[0], lo[6:1]};
      default: addr_of = {hi, lo};
    endcase
  endfunction

  function automatic logic [15:0] adv_x40(logic [15:0] p, logic bump_y);
    adv_x40 = p;
    if (p[5:0] == crtcp_pkg::LAST_X40) begin
      adv_x40[5:0] = 6'h00;
      if (bump_y) begin
        adv_x40[12:8] = p[12:8] + 5'h01;
      end
    end else begin
      adv_x40[5:0] = p[5:0] + 6'h01;
    end
  endfunction

  function automatic logic [15:0] adv_x80(logic [15:0] p);
    adv_x80 = p;
    adv_x80[6:0] = (p[6:0] == crtcp_pkg::LAST_X80) ? 7'h00 : p[6:0] + 7'h01;
  endfunction

  function automatic logic [15:0] adv_byte(logic [15:0] p, logic bump_y);
    logic [6:0] x;
    x = {1'b0, p[5:0]} + 7'h01;
    adv_byte = p;
    adv_byte[5:0] = x[5:0];
    if (x[6] && bump_y) begin
      adv_byte[12:8] = p[12:8] + 5'h01;
    end
  endfunction

  assign as_fall = s_reg.as_d & ~s_reg.as_s2;
  assign ds_rise = ~s_reg.ds_d & s_reg.ds_s2;
  assign wr_hit  = ds_rise & s_reg.sel & ~s_reg.rw_s2;
  assign go      = ds_rise & s_reg.sel & s_reg.execute_request_bit &
                   (~s_reg.busy | (wr_hit & (s_reg.idx == crtcp_pkg::R_CMD)));
  assign cmd     = s_reg.rf[crtcp_pkg::R_CMD];
  assign typ     = cmd[7:4];
  assign dir     = cmd[crtcp_pkg::BIT_DIR];
  assign inc     = cmd[crtcp_pkg::BIT_INC];
  assign is_move = typ >= crtcp_pkg::TYP_MOVE;
  assign is_mem  = is_move | (typ <= crtcp_pkg::TYP_S40S);
  assign psec    = (typ == crtcp_pkg::TYP_L40S) | (typ == crtcp_pkg::TYP_S40S) |
                   ((typ == crtcp_pkg::TYP_BYTE) & cmd[crtcp_pkg::BIT_PSEL]);
  assign src_sec = cmd[3:2] == crtcp_pkg::SRC_S2P;
  assign use_sec = is_move ? ((s_reg.step == 2'h0) ? src_sec : ~src_sec) : psec;
  assign p_hi    = use_sec ? s_reg.rf[crtcp_pkg::R_SHI] : s_reg.rf[crtcp_pkg::R_PHI];
  assign p_lo    = use_sec ? s_reg.rf[crtcp_pkg::R_SLO] : s_reg.rf[crtcp_pkg::R_PLO];
  assign last    = step_last(typ, dir);
  assign cur_addr = addr_of(is_move ? crtcp_pkg::TYP_BYTE : typ, s_reg.step,
                            p_hi, p_lo);
  assign dst     = (typ == crtcp_pkg::TYP_L80 && s_reg.step != 2'h0) ? crtcp_pkg::R_D3 :
                   3'(s_reg.step) + crtcp_pkg::R_D1;
  assign cur_we  = is_move ? (s_reg.step == 2'h1) :
                   ~dir & ~((typ == crtcp_pkg::TYP_L80) & (s_reg.step == 2'h1));
  // Nibble merge: even position owns the low nibble
  assign merged  = p_lo[0] ? {s_reg.rf[crtcp_pkg::R_D3][7:4], s_reg.hold[3:0]}
                           : {s_reg.hold[7:4], s_reg.rf[crtcp_pkg::R_D3][3:0]};
  assign rd_nib  = p_lo[0] ? {mem_rdata_in[7:4], mem_rdata_in[7:4]}
                           : {mem_rdata_in[3:0], mem_rdata_in[3:0]};
  assign susp    = row_edge_in & (cmd != crtcp_pkg::CMD_SMASK) &
                   (cmd != crtcp_pkg::CMD_SUNMK);
  assign status  = {s_reg.busy, s_reg.wrap, s_reg.row_end_flag_primary, s_reg.row_end_flag_secondary, 4'h0};
  assign at_end  = ((typ == crtcp_pkg::TYP_L80) | (typ == crtcp_pkg::TYP_S80)) ?
                   (p_lo[6:0] == crtcp_pkg::LAST_X80) :
                   (typ != crtcp_pkg::TYP_BYTE) & (p_lo[5:0] == crtcp_pkg::LAST_X40);
  assign end_hit = (s_reg.rf[crtcp_pkg::R_SLO][5:0] == crtcp_pkg::LAST_X40) |
                   (s_reg.rf[crtcp_pkg::R_PLO][5:0] == crtcp_pkg::LAST_X40);
  assign upd     = ((typ == crtcp_pkg::TYP_L80) | (typ == crtcp_pkg::TYP_S80)) ?
                   adv_x80({p_hi, p_lo}) :
                   (typ == crtcp_pkg::TYP_BYTE) ? adv_byte({p_hi, p_lo}, ~psec) :
                   adv_x40({p_hi, p_lo}, 1'b0);

  always_comb begin
    s_next = s_reg;
    s_next.as_s1 = latch_strobe_in;
    s_next.as_s2 = s_reg.as_s1;
    s_next.as_d  = s_reg.as_s2;
    s_next.ds_s1 = transfer_strobe_n_in;
    s_next.ds_s2 = s_reg.ds_s1;
    s_next.ds_d  = s_reg.ds_s2;
    s_next.rw_s1 = read_not_write_in;
    s_next.rw_s2 = s_reg.rw_s1;
    s_next.cs_s1 = chip_select_n_in;
    s_next.cs_s2 = s_reg.cs_s1;
    s_next.ad_s1 = ad_in;
    s_next.ad_s2 = s_reg.ad_s1;
    if (as_fall) begin
      s_next.idx = s_reg.ad_s2[2:0];
      s_next.execute_request_bit = s_reg.ad_s2[3];
      s_next.sel = (s_reg.ad_s2[7:4] == crtcp_pkg::SEL_NIB) & ~s_reg.cs_s2;
    end
    // Drive only in a selected read data phase
    s_next.ad_oe = s_reg.sel & ~s_reg.as_s2 & ~s_reg.ds_s2 & s_reg.rw_s2;
    if (s_reg.idx == crtcp_pkg::R_CMD) begin
      s_next.ad_out = status;
    end else if (s_reg.busy) begin
      s_next.ad_out = crtcp_pkg::UNDEF_RD;
    end else begin
      s_next.ad_out = s_reg.rf[s_reg.idx];
    end
    unique case (s_reg.state)
      crtcp_pkg::CRTCP_IDLE: begin
      end
      crtcp_pkg::CRTCP_ISSUE: begin
        if (s_reg.mem_req) begin
          if (mem_ack_in) begin
            s_next.mem_req = 1'b0;
            if (!s_reg.mem_we) begin
              if (is_move) begin
                s_next.rf[crtcp_pkg::R_D1] = mem_rdata_in;
              end else if (typ == crtcp_pkg::TYP_L80 && s_reg.step == 2'h1) begin
                if (dir) begin
                  s_next.rf[crtcp_pkg::R_D3] = rd_nib;
                end else begin
                  s_next.hold = mem_rdata_in;
                end
              end else begin
                s_next.rf[dst] = mem_rdata_in;
              end
            end
            if (s_reg.step == last) begin
              s_next.state = crtcp_pkg::CRTCP_FINISH;
            end else begin
              s_next.step = s_reg.step + 2'h1;
            end
          end
        end else if (!susp) begin
          if (is_mem) begin
            s_next.mem_req   = 1'b1;
            s_next.mem_we    = cur_we;
            s_next.mem_addr  = cur_addr;
            s_next.mem_wdata = is_move ? s_reg.rf[crtcp_pkg::R_D1] :
                               (typ == crtcp_pkg::TYP_L80 && s_reg.step == 2'h2) ?
                               merged : s_reg.rf[dst];
          end else begin
            if (typ == crtcp_pkg::TYP_IND) begin
              if (dir) begin
                s_next.rf[crtcp_pkg::R_D1] = s_reg.indirect_transfer_cmd[cmd[2:0]];
              end else begin
                s_next.indirect_transfer_cmd[cmd[2:0]] = s_reg.rf[crtcp_pkg::R_D1];
              end
            end else if (cmd == crtcp_pkg::CMD_SMASK) begin
              s_next.smask = 1'b1;
            end else if (cmd == crtcp_pkg::CMD_SUNMK) begin
              s_next.smask = 1'b0;
            end
            s_next.busy  = 1'b0;
            s_next.state = crtcp_pkg::CRTCP_IDLE;
          end
        end
      end
      crtcp_pkg::CRTCP_FINISH: begin
        s_next.busy  = 1'b0;
        s_next.state = crtcp_pkg::CRTCP_IDLE;
        s_next.step  = 2'h0;
        if (is_move) begin
          {s_next.rf[crtcp_pkg::R_PHI], s_next.rf[crtcp_pkg::R_PLO]} =
            adv_x40({s_reg.rf[crtcp_pkg::R_PHI], s_reg.rf[crtcp_pkg::R_PLO]}, 1'b1);
          {s_next.rf[crtcp_pkg::R_SHI], s_next.rf[crtcp_pkg::R_SLO]} =
            adv_x40({s_reg.rf[crtcp_pkg::R_SHI], s_reg.rf[crtcp_pkg::R_SLO]}, 1'b0);
          if ((cmd[1:0] == crtcp_pkg::STOP_NONE) ||
              (cmd[1:0] == crtcp_pkg::STOP_END && !end_hit)) begin
            s_next.busy  = 1'b1;
            s_next.state = crtcp_pkg::CRTCP_ISSUE;
          end
        end else begin
          if (at_end) begin
            s_next.row_end_flag_primary  = s_reg.row_end_flag_primary | ~psec;
            s_next.row_end_flag_secondary  = s_reg.row_end_flag_secondary | psec;
            s_next.wrap = s_reg.wrap | inc;
          end
          if (inc && psec) begin
            {s_next.rf[crtcp_pkg::R_SHI], s_next.rf[crtcp_pkg::R_SLO]} = upd;
          end else if (inc) begin
            {s_next.rf[crtcp_pkg::R_PHI], s_next.rf[crtcp_pkg::R_PLO]} = upd;
          end
        end
      end
    endcase
    if (wr_hit) begin
      if (s_reg.idx == crtcp_pkg::R_CMD) begin
        if (!s_reg.busy || s_reg.execute_request_bit) begin
          s_next.rf[crtcp_pkg::R_CMD] = s_reg.ad_s2;
        end
      end else if (!s_reg.busy) begin
        s_next.rf[s_reg.idx] = s_reg.ad_s2;
      end
    end
    if (go) begin
      s_next.busy    = 1'b1;
      s_next.state   = crtcp_pkg::CRTCP_ISSUE;
      s_next.step    = 2'h0;
      s_next.mem_req = 1'b0;
      s_next.wrap    = 1'b0;
      s_next.row_end_flag_primary     = 1'b0;
      s_next.row_end_flag_secondary     = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_reg       <= '0;
      s_reg.state <= crtcp_pkg::CRTCP_IDLE;
      s_reg.as_s1 <= 1'b1;
      s_reg.as_s2 <= 1'b1;
      s_reg.as_d  <= 1'b1;
      s_reg.ds_s1 <= 1'b1;
      s_reg.ds_s2 <= 1'b1;
      s_reg.ds_d  <= 1'b1;
      s_reg.cs_s1 <= 1'b1;
      s_reg.cs_s2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ad_out        = s_reg.ad_out;
  assign ad_oe_out     = s_reg.ad_oe;
  assign mem_req_out   = s_reg.mem_req;
  assign mem_we_out    = s_reg.mem_we;
  assign mem_addr_out  = s_reg.mem_addr;
  assign mem_wdata_out = s_reg.mem_wdata;
  assign sync_mask_out = s_reg.smask;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_latch;
    as_fall |=> s_reg.idx == $past(s_reg.ad_s2[2:0]) && s_reg.execute_request_bit == $past(s_reg.ad_s2[3]);
  endproperty
  a_latch: assert property (p_latch)
    else $error("address latch wrong");
  property p_sel;
    as_fall |=> s_reg.sel == ($past(s_reg.ad_s2[7:4]) == crtcp_pkg::SEL_NIB &&
                              !$past(s_reg.cs_s2));
  endproperty
  a_sel: assert property (p_sel)
    else $error("select decode wrong");
  property p_float;
    !s_reg.sel |=> !ad_oe_out;
  endproperty
  a_float: assert property (p_float)
    else $error("bus driven while unselected");
  property p_unsel_keep;
    ds_rise && !s_reg.sel && s_reg.state == crtcp_pkg::CRTCP_IDLE |=> $stable(s_reg.rf);
  endproperty
  a_unsel_keep: assert property (p_unsel_keep)
    else $error("register changed while unselected");
  property p_drive;
    s_reg.sel && !s_reg.as_s2 && !s_reg.ds_s2 && s_reg.rw_s2 |=> ad_oe_out;
  endproperty
  a_drive: assert property (p_drive)
    else $error("selected read not driven");
  property p_status;
    ad_oe_out && s_reg.idx == crtcp_pkg::R_CMD |-> ad_out[7:6] == $past({s_reg.busy, s_reg.wrap});
  endproperty
  a_status: assert property (p_status)
    else $error("status bits wrong");
  property p_start;
    go |=> s_reg.busy && s_reg.state == crtcp_pkg::CRTCP_ISSUE && s_reg.step == 2'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("command did not start");
  property p_lock;
    ds_rise && s_reg.busy && !s_reg.execute_request_bit |=> $stable(s_reg.rf[crtcp_pkg::R_CMD]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("command changed while busy");
  property p_abort;
    go && s_reg.busy |=> s_reg.step == 2'h0 && !mem_req_out;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not restart");
  property p_suspend;
    s_reg.state == crtcp_pkg::CRTCP_ISSUE && !s_reg.mem_req && susp |=> !mem_req_out;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("request issued during row edge");
  property p_wrap;
    s_reg.state == crtcp_pkg::CRTCP_FINISH && !is_move && inc && at_end && !go
    |=> s_reg.wrap && !s_reg.busy;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap alarm missing");
  property p_carry;
    s_reg.state == crtcp_pkg::CRTCP_FINISH && typ == crtcp_pkg::TYP_BYTE && inc && !psec &&
    p_lo[5:0] == 6'h3f |=> s_reg.rf[crtcp_pkg::R_PHI][4:0] ==
    $past(s_reg.rf[crtcp_pkg::R_PHI][4:0]) + 5'h01;
  endproperty
  a_carry: assert property (p_carry)
    else $error("row not incremented on overflow");
  c_start: cover property (go && !s_reg.busy);
  c_abort: cover property (go && s_reg.busy);
  c_wrap: cover property (s_reg.state == crtcp_pkg::CRTCP_FINISH && inc && at_end);
  c_susp: cover property (s_reg.state == crtcp_pkg::CRTCP_ISSUE && susp);
endmodule
`default_nettype wire

// [pkg/crtcp_pkg.sv]
package crtcp_pkg;
  // Command types (upper nibble of the command byte)
  localparam logic [3:0] TYP_L40P  = 4'h0;
  localparam logic [3:0] TYP_L40S  = 4'h2;
  localparam logic [3:0] TYP_BYTE  = 4'h3;
  localparam logic [3:0] TYP_S80   = 4'h4;
  localparam logic [3:0] TYP_L80   = 4'h5;
  localparam logic [3:0] TYP_S40P  = 4'h6;
  localparam logic [3:0] TYP_S40S  = 4'h7;
  localparam logic [3:0] TYP_IND   = 4'h8;
  localparam logic [3:0] TYP_MISC  = 4'h9;
  localparam logic [3:0] TYP_MOVE  = 4'hd;
  localparam logic [7:0] CMD_SMASK = 8'h99;
  localparam logic [7:0] CMD_SUNMK = 8'h95;
  // Parameter bit positions and field codes
  localparam int         BIT_DIR   = 3;
  localparam int         BIT_PSEL  = 2;
  localparam int         BIT_INC   = 0;
  localparam logic [1:0] SRC_P2S   = 2'h1;
  localparam logic [1:0] SRC_S2P   = 2'h2;
  localparam logic [1:0] STOP_END  = 2'h1;
  localparam logic [1:0] STOP_NONE = 2'h2;
  // Direct register indexes
  localparam logic [2:0] R_CMD     = 3'h0;
  localparam logic [2:0] R_D1      = 3'h1;
  localparam logic [2:0] R_D2      = 3'h2;
  localparam logic [2:0] R_D3      = 3'h3;
  localparam logic [2:0] R_SHI     = 3'h4;
  localparam logic [2:0] R_SLO     = 3'h5;
  localparam logic [2:0] R_PHI     = 3'h6;
  localparam logic [2:0] R_PLO     = 3'h7;
  // Select decode, positions, read values
  localparam logic [3:0] SEL_NIB   = 4'h2;
  localparam logic [5:0] LAST_X40  = 6'h27;
  localparam logic [6:0] LAST_X80  = 7'h4f;
  localparam logic [7:0] UNDEF_RD  = 8'hff;
  localparam logic [1:0] NIB_BUF   = 2'h2;
  typedef enum logic [2:0] {
    CRTCP_IDLE   = 3'b001,
    CRTCP_ISSUE  = 3'b010,
    CRTCP_FINISH = 3'b100
  } crtcp_state_e;
endpackage

// [test/crtcp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module crtcp_host_model (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] dev_ad_in,
  input  wire logic       dev_oe_in,
  output logic      [7:0] ad_out,
  output logic            latch_out,
  output logic            ds_n_out,
  output logic            rnw_out,
  output logic            cs_n_out
);
  logic [7:0] val;
  logic       drv;

  // Released bus drifts to the inverse of the last value, never a stale copy
  assign ad_out = dev_oe_in ? dev_ad_in : (drv ? val : ~val);

  initial begin
    val = 8'h00;
    drv = 1'b0;
    latch_out = 1'b1;
    ds_n_out = 1'b1;
    rnw_out = 1'b1;
    cs_n_out = 1'b1;
  end

  // One multiplexed bus cycle; each phase held well past the synchroniser delay
  task automatic cycle(input logic [7:0] adr, input logic cs_n, input logic rd,
                       input logic [7:0] wd, output logic [7:0] rdv, output logic oe);
    @(negedge clk_sys_in);
    val = adr;
    drv = 1'b1;
    cs_n_out = cs_n;
    rnw_out = rd;
    repeat (2) @(negedge clk_sys_in);
    latch_out = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    val = wd;
    drv = !rd;
    ds_n_out = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    rdv = dev_ad_in;
    oe = dev_oe_in;
    ds_n_out = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    latch_out = 1'b1;
    drv = 1'b0;
    repeat (5) @(negedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        row_edge = 1'b0;
  logic [7:0]  bus_ad;
  logic        h_ls;
  logic        h_ds_n;
  logic        h_rnw;
  logic        h_cs_n;
  logic [7:0]  d_ad;
  logic        d_oe;
  logic        mem_req;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        sync_mask;
  logic [7:0]  mem [0:65535];
  logic        ack = 1'b0;
  logic [7:0]  rdat = 8'h00;
  logic [1:0]  cnt = 2'h0;
  logic [1:0]  lat = 2'h1;
  logic [7:0]  rd_v;
  logic        oe_v;
  int          fails = 0;
  int          checks = 0;

  always #4 clk_sys_in = ~clk_sys_in;

  crtcp_host_model host_u (
    .clk_sys_in (clk_sys_in),
    .dev_ad_in  (d_ad),
    .dev_oe_in  (d_oe),
    .ad_out     (bus_ad),
    .latch_out  (h_ls),
    .ds_n_out   (h_ds_n),
    .rnw_out    (h_rnw),
    .cs_n_out   (h_cs_n)
  );

  crtcp_host_port dut_u (
    .clk_sys_in           (clk_sys_in),
    .rst_in               (rst_in),
    .ad_in                (bus_ad),
    .ad_out               (d_ad),
    .ad_oe_out            (d_oe),
    .latch_strobe_in      (h_ls),
    .transfer_strobe_n_in (h_ds_n),
    .read_not_write_in    (h_rnw),
    .chip_select_n_in     (h_cs_n),
    .row_edge_in          (row_edge),
    .mem_req_out          (mem_req),
    .mem_we_out           (mem_we),
    .mem_addr_out         (mem_addr),
    .mem_wdata_out        (mem_wdata),
    .mem_rdata_in         (rdat),
    .mem_ack_in           (ack),
    .sync_mask_out        (sync_mask)
  );

  // Page memory: acks after a settable latency, one pulse per request
  always @(posedge clk_sys_in) begin
    ack <= 1'b0;
    if (mem_req && !ack) begin
      cnt <= cnt + 2'h1;
      if (cnt >= lat) begin
        ack <= 1'b1;
        cnt <= 2'h0;
        rdat <= mem[mem_addr];
        if (mem_we) mem[mem_addr] <= mem_wdata;
      end
    end
  end

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.cycle(a, 1'b0, 1'b0, d, rd_v, oe_v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    host_u.cycle(a, 1'b0, 1'b1, 8'h00, rd_v, oe_v);
    chk(n, e, rd_v);
  endtask

  // Issue a command with execute request, then poll status until idle
  task automatic run(input logic [7:0] c);
    int i;
    wr(8'h28, c);
    for (i = 0; i < 40; i++) begin
      host_u.cycle(8'h20, 1'b0, 1'b1, 8'h00, rd_v, oe_v);
      if (rd_v[7] === 1'b0) break;
    end
    if (i == 40) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic s_reset();
    rd(8'h20, 8'h00, "status after reset");
    run(8'h91);
    rd(8'h20, 8'h00, "status after idle");
  endtask

  task automatic s_regs();
    for (int i = 1; i < 8; i++) wr(8'h20 + i[7:0], 8'h11 * i[7:0]);
    for (int i = 1; i < 8; i++) rd(8'h20 + i[7:0], 8'h11 * i[7:0], "direct reg");
    wr(8'h20, 8'h31);
    rd(8'h20, 8'h00, "status not command");
  endtask

  task automatic s_unsel();
    host_u.cycle(8'h21, 1'b1, 1'b0, 8'hee, rd_v, oe_v);
    wr(8'h31, 8'hee);
    wr(8'h01, 8'hee);
    host_u.cycle(8'h21, 1'b1, 1'b1, 8'h00, rd_v, oe_v);
    chk("float oe", 8'h00, {7'h00, oe_v});
    rd(8'h21, 8'h11, "reg kept");
  endtask

  task automatic s_byte();
    lat = 2'h0;
    wr(8'h26, 8'h03);
    wr(8'h27, 8'h05);
    wr(8'h21, 8'ha5);
    run(8'h31);
    chk("byte wr", 8'ha5, mem[16'h0305]);
    rd(8'h27, 8'h06, "ptr inc");
    mem[16'h0306] = 8'h3c;
    lat = 2'h3;
    run(8'h39);
    rd(8'h21, 8'h3c, "byte rd");
    rd(8'h27, 8'h07, "ptr inc");
    wr(8'h24, 8'h01);
    wr(8'h25, 8'h10);
    run(8'h34);
    chk("sec wr", 8'h3c, mem[16'h0110]);
    rd(8'h25, 8'h10, "no inc");
    wr(8'h27, 8'h3f);
    run(8'h31);
    rd(8'h27, 8'h00, "x wrap");
    rd(8'h26, 8'h04, "row inc");
  endtask

  task automatic s_long();
    wr(8'h26, 8'h02);
    wr(8'h27, 8'h67);
    wr(8'h21, 8'hc1);
    wr(8'h22, 8'hb2);
    wr(8'h23, 8'ha3);
    run(8'h01);
    chk("c byte", 8'hc1, mem[16'h0267]);
    chk("b byte", 8'hb2, mem[16'h02a7]);
    chk("a byte", 8'ha3, mem[16'h02e7]);
    rd(8'h27, 8'h40, "x wrap");
    rd(8'h26, 8'h02, "no row inc");
    rd(8'h20, 8'h60, "alarm flags");
  endtask

  task automatic s_ind();
    wr(8'h21, 8'h5a);
    run(8'h81);
    wr(8'h21, 8'h00);
    run(8'h89);
    rd(8'h21, 8'h5a, "indirect");
  endtask

  task automatic s_k80();
    wr(8'h26, 8'h05);
    wr(8'h27, 8'h03);
    wr(8'h21, 8'h7e);
    run(8'h41);
    chk("short80 wr", 8'h7e, mem[16'h0541]);
    rd(8'h27, 8'h04, "x80 inc");
    wr(8'h27, 8'h02);
    mem[16'h0581] = 8'h9c;
    wr(8'h21, 8'h4d);
    wr(8'h23, 8'h66);
    run(8'h50);
    chk("long80 c", 8'h4d, mem[16'h0501]);
    chk("long80 nib", 8'h96, mem[16'h0581]);
    wr(8'h21, 8'h00);
    wr(8'h23, 8'h00);
    run(8'h58);
    rd(8'h21, 8'h4d, "long80 rd c");
    rd(8'h23, 8'h66, "long80 rd nib");
  endtask

  task automatic s_busy();
    wr(8'h22, 8'h22);
    wr(8'h20, 8'h99);
    chk("no start", 8'h00, {7'h00, sync_mask});
    row_edge = 1'b1;
    wr(8'h28, 8'h39);
    rd(8'h20, 8'h80, "busy");
    chk("stalled req", 8'h00, {7'h00, mem_req});
    rd(8'h22, 8'hff, "busy read");
    wr(8'h22, 8'h77);
    run(8'h99);
    chk("mask set", 8'h01, {7'h00, sync_mask});
    row_edge = 1'b0;
    rd(8'h22, 8'h22, "write ignored");
    run(8'h95);
    chk("mask clr", 8'h00, {7'h00, sync_mask});
  endtask

  initial begin
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
    s_reset();
    s_regs();
    s_unsel();
    s_byte();
    s_long();
    s_ind();
    s_k80();
    s_busy();
    wrap_up();
  end
endmodule
`default_nettype wire
